/* File: rtl/hcl_regs.vh */
// constants for the hub configuration loader: image layout, defaults, register map
// assumes inclusion by bare name from each design file of the loader
`ifndef HCL_REGS_VH
`define HCL_REGS_VH

// image signature values
`define HCL_SIG_EXT        8'hD4
`define HCL_SIG_BLANK      8'hFF

// serial memory read command and start address
`define HCL_CMD_READ       8'h03
`define HCL_START_ADDR     16'h0000
`define HCL_HDR_BITS       9'd24

// image byte positions
`define HCL_B_SIG          6'd0
`define HCL_B_VID_LO       6'd1
`define HCL_B_VID_HI       6'd2
`define HCL_B_PID_LO       6'd3
`define HCL_B_PID_HI       6'd4
`define HCL_B_DEVREL_HI    6'd6
`define HCL_B_OC_TIMERS    6'd7
`define HCL_B_DRAW_FS      6'd8
`define HCL_B_DRAW_HS      6'd9
`define HCL_B_RSVD_A       6'd10
`define HCL_B_RSVD_B       6'd11
`define HCL_B_CUR_FS_BUS   6'd12
`define HCL_B_CUR_HS_BUS   6'd13
`define HCL_B_CUR_FS_SELF  6'd14
`define HCL_B_CUR_HS_SELF  6'd15
`define HCL_B_PGOOD        6'd16
`define HCL_B_FLAGS_A      6'd17
`define HCL_B_FLAGS_B      6'd18
`define HCL_B_LANGS        6'd20
`define HCL_B_LANGID_LO    6'd24
`define HCL_B_LANGID_HI    6'd25
`define HCL_IMAGE_BYTES    6'd26
`define HCL_TBL_BASE       16'd24

// field positions inside image bytes
`define HCL_FA_COMPOUND    6
`define HCL_FA_NO_IND      4
`define HCL_FA_GANG        2
`define HCL_FB_OC_DIS      1
`define HCL_FB_OC_PORT     0

// hub characteristics bit positions
`define HCL_HC_IND         7
`define HCL_HC_OC_DIS      4
`define HCL_HC_OC_PORT     3
`define HCL_HC_COMPOUND    2

// reset values (typical image content)
`define HCL_RST_VID        16'h0000
`define HCL_RST_PID        16'h0000
`define HCL_RST_DEVREL     8'h00
`define HCL_RST_OC_TIMERS  8'h88
`define HCL_RST_DRAW_FS    8'h28
`define HCL_RST_DRAW_HS    8'h57
`define HCL_RST_CUR_FS_BUS 8'h50
`define HCL_RST_CUR_HS_BUS 8'hAE
`define HCL_RST_CUR_FS_SLF 8'h50
`define HCL_RST_CUR_HS_SLF 8'h64
`define HCL_RST_PGOOD      8'h32
`define HCL_RST_FLAGS_A    8'h80
`define HCL_RST_FLAGS_B    8'h00

// apb register byte offsets
`define HCL_REG_CTRL       12'h000
`define HCL_REG_STATUS     12'h004
`define HCL_REG_IDS        12'h008
`define HCL_REG_MISC       12'h00C
`define HCL_REG_POWER      12'h010
`define HCL_REG_TIMING     12'h014
`define HCL_REG_LANG       12'h018
`define HCL_REG_TBL_AB     12'h01C
`define HCL_REG_TBL_CD     12'h020
`define HCL_REG_TBL_EF     12'h024

`endif

/* File: rtl/hcl_spi_reader.v */
// sequential byte reader for a serial memory: one read command, then a stream of bytes
// assumes miso is already synchronised to pclk and start is a one-cycle pulse
`timescale 1ns/1ps
`include "hcl_regs.vh"

module hcl_spi_reader #(
    parameter DIV = 4
) (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       start,
    input  wire [5:0] byte_count,
    input  wire       miso_s,
    output reg        spi_sck,
    output reg        spi_cs_n,
    output reg        spi_mosi,
    output reg  [7:0] rd_byte,
    output reg        rd_valid,
    output reg        rd_done,
    output wire       busy
);
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN  = 2'b10;

    reg [1:0]  state_q;
    reg [7:0]  div_q;
    reg [8:0]  bit_q;
    reg [8:0]  total_q;
    reg [23:0] tx_q;
    reg [6:0]  rx_q;

    assign busy = state_q[1];

    // mode 0: sample on rising sck, shift out on falling sck
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= ST_IDLE;
            div_q    <= 8'h00;
            bit_q    <= 9'h000;
            total_q  <= 9'h000;
            tx_q     <= 24'h000000;
            rx_q     <= 7'h00;
            spi_sck  <= 1'b0;
            spi_cs_n <= 1'b1;
            spi_mosi <= 1'b0;
            rd_byte  <= 8'h00;
            rd_valid <= 1'b0;
            rd_done  <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            rd_done  <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q  <= ST_RUN;
                        spi_cs_n <= 1'b0;
                        spi_sck  <= 1'b0;
                        tx_q     <= {`HCL_CMD_READ, `HCL_START_ADDR};
                        spi_mosi <= 1'b0; // command msb is zero
                        bit_q    <= 9'h000;
                        div_q    <= 8'h00;
                        total_q  <= `HCL_HDR_BITS + {byte_count, 3'b000};
                    end
                end
                ST_RUN: begin
                    if (div_q == DIV[7:0] - 8'h01) begin
                        div_q <= 8'h00;
                        if (!spi_sck) begin
                            spi_sck <= 1'b1;
                            rx_q    <= {rx_q[5:0], miso_s};
                            bit_q   <= bit_q + 9'h001;
                            // header is a whole number of bytes, so low bits mark byte ends
                            if (bit_q >= `HCL_HDR_BITS && bit_q[2:0] == 3'b111) begin
                                rd_byte  <= {rx_q, miso_s};
                                rd_valid <= 1'b1;
                            end
                        end else if (bit_q == total_q) begin
                            spi_sck  <= 1'b0;
                            spi_cs_n <= 1'b1;
                            state_q  <= ST_IDLE;
                            rd_done  <= 1'b1;
                        end else begin
                            spi_sck  <= 1'b0;
                            tx_q     <= {tx_q[22:0], 1'b0};
                            spi_mosi <= tx_q[22];
                        end
                    end else begin
                        div_q <= div_q + 8'h01;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

/* File: rtl/hcl_loader.v */
// hub configuration loader: reads the extended image from serial memory at start-up
// and holds the descriptor fields; registers visible over apb with zero wait states
// assumes usb_high_speed and self_powered come from logic on pclk
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "hcl_regs.vh"

// What this block does
// - image counts as extended format only when byte 0 equals 0xD4
// - vendor id: byte 1 low half, byte 2 high half
// - product id: byte 3 low, byte 4 high; byte 5 ignored
// - byte 6 is the upper byte of the device release id
// - byte 7: upper nibble active-port filter ms, lower idle-port
// - full speed upstream reports byte 8 as draw in 2 mA units
// - high speed upstream reports byte 9 as draw in 2 mA units
// - bus powered full speed reports byte 12 as controller current
// - bus powered high speed reports byte 13 as controller current
// - self powered full speed reports byte 14 as controller current
// - self powered high speed reports byte 15 as controller current
// - byte 16 reported as port power good delay in 2 ms steps
// - overcurrent disable bit turns detection off, shown as characteristics bit 4
// - string tables: two-byte entries low first, one per language, back to back
// - blank memory reading 0xFF enumerates as vendor class, not hub
module hcl_loader #(
    parameter SPI_DIV = 4
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output reg         pslverr,
    output wire        spi_sck,
    output wire        spi_cs_n,
    output wire        spi_mosi,
    input  wire        spi_miso,
    input  wire        usb_high_speed,
    input  wire        self_powered,
    output wire [15:0] vendor_id,
    output wire [15:0] product_id,
    output wire [15:0] device_release_id,
    output wire [3:0]  active_port_oc_filter_ms,
    output wire [3:0]  idle_port_oc_filter_ms,
    output reg  [7:0]  upstream_draw_2ma,
    output reg  [7:0]  controller_current_ma,
    output wire [7:0]  port_power_good_delay,
    output wire        oc_detect_disable,
    output reg  [15:0] hub_characteristics,
    output wire        vendor_class_mode,
    output wire        config_ready
);
    localparam ST_BOOT = 3'b001;
    localparam ST_LOAD = 3'b010;
    localparam ST_DONE = 3'b100;

    reg  [2:0]  state_q;
    reg         start_q;
    reg  [5:0]  idx_q;
    reg         miso_m_q;
    reg         miso_s_q;
    reg         ext_q;
    reg         blank_q;
    reg         bad_sig_q;
    reg         rsvd_nz_q;
    reg         done_q;
    reg  [15:0] vid_q;
    reg  [15:0] pid_q;
    reg  [7:0]  devrel_q;
    reg  [7:0]  oc_timers_q;
    reg  [7:0]  draw_fs_q;
    reg  [7:0]  draw_hs_q;
    reg  [7:0]  cur_fs_bus_q;
    reg  [7:0]  cur_hs_bus_q;
    reg  [7:0]  cur_fs_slf_q;
    reg  [7:0]  cur_hs_slf_q;
    reg  [7:0]  pgood_q;
    reg  [7:0]  flags_a_q;
    reg  [7:0]  flags_b_q;
    reg  [7:0]  langs_q;
    reg  [15:0] langid_q;
    reg  [15:0] hc_d;
    wire [7:0]  rd_byte;
    wire        rd_valid;
    wire        rd_done;
    wire        rd_busy;
    wire        wr_en;
    wire        rd_en;
    wire        reload;

    // byte address of string table k (0 = manufacturer); tables follow each other
    function [15:0] tbl_base;
        input [7:0] langs;
        input [2:0] k;
        begin
            tbl_base = `HCL_TBL_BASE + ({5'h00, k} + 8'h01) * {7'h00, langs, 1'b0};
        end
    endfunction

    // miso is a pin: two flops before any logic looks at it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            miso_m_q <= 1'b0;
            miso_s_q <= 1'b0;
        end else begin
            miso_m_q <= spi_miso;
            miso_s_q <= miso_m_q;
        end
    end

    hcl_spi_reader #(
        .DIV (SPI_DIV)
    ) u_reader (
        .pclk       (pclk),
        .presetn    (presetn),
        .start      (start_q),
        .byte_count (`HCL_IMAGE_BYTES),
        .miso_s     (miso_s_q),
        .spi_sck    (spi_sck),
        .spi_cs_n   (spi_cs_n),
        .spi_mosi   (spi_mosi),
        .rd_byte    (rd_byte),
        .rd_valid   (rd_valid),
        .rd_done    (rd_done),
        .busy       (rd_busy)
    );

    // apb decode: zero wait states, so access completes in the first access cycle
    assign pready = 1'b1;
    assign wr_en  = psel & penable & pwrite;
    assign rd_en  = psel & penable & ~pwrite;
    assign reload = wr_en & (paddr == `HCL_REG_CTRL) & pwdata[0];

    // sequencer: boot load after reset, software reload only once idle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_BOOT;
            start_q <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            start_q <= 1'b0;
            case (state_q)
                ST_BOOT: begin
                    start_q <= 1'b1;
                    done_q  <= 1'b0;
                    state_q <= ST_LOAD;
                end
                ST_LOAD: begin
                    if (rd_done) begin
                        done_q  <= 1'b1;
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (reload) begin
                        state_q <= ST_BOOT;
                    end
                end
                default: state_q <= ST_BOOT;
            endcase
        end
    end

    // image capture; fields past the signature only taken for a valid image,
    // so a foreign or blank image leaves the values from reset or from the last valid load in place
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_q        <= 6'h00;
            ext_q        <= 1'b0;
            blank_q      <= 1'b0;
            bad_sig_q    <= 1'b0;
            rsvd_nz_q    <= 1'b0;
            vid_q        <= `HCL_RST_VID;
            pid_q        <= `HCL_RST_PID;
            devrel_q     <= `HCL_RST_DEVREL;
            oc_timers_q  <= `HCL_RST_OC_TIMERS;
            draw_fs_q    <= `HCL_RST_DRAW_FS;
            draw_hs_q    <= `HCL_RST_DRAW_HS;
            cur_fs_bus_q <= `HCL_RST_CUR_FS_BUS;
            cur_hs_bus_q <= `HCL_RST_CUR_HS_BUS;
            cur_fs_slf_q <= `HCL_RST_CUR_FS_SLF;
            cur_hs_slf_q <= `HCL_RST_CUR_HS_SLF;
            pgood_q      <= `HCL_RST_PGOOD;
            flags_a_q    <= `HCL_RST_FLAGS_A;
            flags_b_q    <= `HCL_RST_FLAGS_B;
            langs_q      <= 8'h00;
            langid_q     <= 16'h0000;
        end else if (start_q) begin
            idx_q     <= 6'h00;
            rsvd_nz_q <= 1'b0;
        end else if (rd_valid) begin
            idx_q <= idx_q + 6'h01;
            if (idx_q == `HCL_B_SIG) begin
                ext_q     <= (rd_byte == `HCL_SIG_EXT);
                blank_q   <= (rd_byte == `HCL_SIG_BLANK);
                bad_sig_q <= (rd_byte != `HCL_SIG_EXT) && (rd_byte != `HCL_SIG_BLANK);
            end else if (ext_q) begin
                case (idx_q)
                    `HCL_B_VID_LO:      vid_q[7:0]   <= rd_byte;
                    `HCL_B_VID_HI:      vid_q[15:8]  <= rd_byte;
                    `HCL_B_PID_LO:      pid_q[7:0]   <= rd_byte;
                    `HCL_B_PID_HI:      pid_q[15:8]  <= rd_byte;
                    `HCL_B_DEVREL_HI:   devrel_q     <= rd_byte;
                    `HCL_B_OC_TIMERS:   oc_timers_q  <= rd_byte;
                    `HCL_B_DRAW_FS:     draw_fs_q    <= rd_byte;
                    `HCL_B_DRAW_HS:     draw_hs_q    <= rd_byte;
                    `HCL_B_RSVD_A,
                    `HCL_B_RSVD_B:      rsvd_nz_q    <= rsvd_nz_q | (|rd_byte);
                    `HCL_B_CUR_FS_BUS:  cur_fs_bus_q <= rd_byte;
                    `HCL_B_CUR_HS_BUS:  cur_hs_bus_q <= rd_byte;
                    `HCL_B_CUR_FS_SELF: cur_fs_slf_q <= rd_byte;
                    `HCL_B_CUR_HS_SELF: cur_hs_slf_q <= rd_byte;
                    `HCL_B_PGOOD:       pgood_q      <= rd_byte;
                    `HCL_B_FLAGS_A:     flags_a_q    <= rd_byte;
                    `HCL_B_FLAGS_B:     flags_b_q    <= rd_byte;
                    `HCL_B_LANGS:       langs_q      <= rd_byte;
                    `HCL_B_LANGID_LO:   langid_q[7:0]  <= rd_byte;
                    `HCL_B_LANGID_HI:   langid_q[15:8] <= rd_byte;
                    default:            langs_q      <= langs_q; // byte 5 and others unused
                endcase
            end
        end
    end

    // hub characteristics word built from the flag bytes
    always @* begin
        hc_d                   = 16'h0000;
        hc_d[1:0]              = flags_a_q[`HCL_FA_GANG] ? 2'b00 : 2'b01;
        hc_d[`HCL_HC_COMPOUND] = flags_a_q[`HCL_FA_COMPOUND];
        hc_d[`HCL_HC_OC_PORT]  = flags_b_q[`HCL_FB_OC_PORT];
        hc_d[`HCL_HC_OC_DIS]   = flags_b_q[`HCL_FB_OC_DIS];
        hc_d[`HCL_HC_IND]      = ~flags_a_q[`HCL_FA_NO_IND];
    end

    // speed and power mode selection registered; inputs may change at any time
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upstream_draw_2ma     <= `HCL_RST_DRAW_FS;
            controller_current_ma <= `HCL_RST_CUR_FS_BUS;
            hub_characteristics   <= 16'h0000;
        end else begin
            upstream_draw_2ma   <= usb_high_speed ? draw_hs_q : draw_fs_q;
            hub_characteristics <= hc_d;
            case ({self_powered, usb_high_speed})
                2'b00:   controller_current_ma <= cur_fs_bus_q;
                2'b01:   controller_current_ma <= cur_hs_bus_q;
                2'b10:   controller_current_ma <= cur_fs_slf_q;
                default: controller_current_ma <= cur_hs_slf_q;
            endcase
        end
    end

    assign vendor_id                = vid_q;
    assign product_id               = pid_q;
    assign device_release_id        = {devrel_q, 8'h00};
    assign active_port_oc_filter_ms = oc_timers_q[7:4];
    assign idle_port_oc_filter_ms   = oc_timers_q[3:0];
    assign port_power_good_delay    = pgood_q;
    assign oc_detect_disable        = flags_b_q[`HCL_FB_OC_DIS];
    // blank memory: hub stays a vendor class device so the part can be programmed
    assign vendor_class_mode        = done_q & blank_q;
    // hub must not connect upstream before every field is latched
    assign config_ready             = done_q;

    // read mux; unmapped addresses read zero with an error
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
            if (psel & ~penable) begin
                case (paddr)
                    `HCL_REG_CTRL:   prdata <= 32'h00000000;
                    `HCL_REG_STATUS: prdata <= {26'h0000000, rsvd_nz_q, bad_sig_q, blank_q, ext_q,
                                                done_q, rd_busy};
                    `HCL_REG_IDS:    prdata <= {pid_q, vid_q};
                    `HCL_REG_MISC:   prdata <= {8'h00, flags_b_q, oc_timers_q, devrel_q};
                    `HCL_REG_POWER:  prdata <= {cur_hs_bus_q, cur_fs_bus_q, draw_hs_q, draw_fs_q};
                    `HCL_REG_TIMING: prdata <= {flags_a_q, pgood_q, cur_hs_slf_q, cur_fs_slf_q};
                    `HCL_REG_LANG:   prdata <= {langid_q, 8'h00, langs_q};
                    `HCL_REG_TBL_AB: prdata <= {tbl_base(langs_q, 3'd1), tbl_base(langs_q, 3'd0)};
                    `HCL_REG_TBL_CD: prdata <= {tbl_base(langs_q, 3'd3), tbl_base(langs_q, 3'd2)};
                    `HCL_REG_TBL_EF: prdata <= {tbl_base(langs_q, 3'd5), tbl_base(langs_q, 3'd4)};
                    default:         pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule

/* File: sim/hcl_eeprom_model.sv */
// serial memory model: configuration image, read command only
// assumes mode 0 and select low for the whole frame
`timescale 1ns/1ps
module hcl_eeprom_model (
    input  wire       sck,
    input  wire       cs_n,
    input  wire       mosi,
    input  wire       slow,
    output wire       miso
);
    reg  [7:0]  mem [0:63];
    reg  [23:0] cmd_q = 24'h000000;
    reg  [8:0]  cnt_q = 9'h000;
    reg         bit_q = 1'b0;
    wire [8:0]  pos   = cnt_q - 9'h018;
    // released line shows the inverse
    assign miso = cs_n ? ~bit_q : bit_q;
    // command shifts in on rising clock
    always @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            cnt_q <= 9'h000;
        end else begin
            cnt_q <= cnt_q + 9'h001;
            if (cnt_q < 9'h018) begin
                cmd_q <= {cmd_q[22:0], mosi};
            end
        end
    end
    // bytes out msb first on falling clock; slow delay kept off the pclk edge
    always @(negedge sck) begin
        if (!cs_n && cnt_q >= 9'h018) begin
            bit_q <= #(slow ? 6 : 0) mem[pos[8:3] + cmd_q[5:0]][3'h7 - pos[2:0]];
        end
    end
endmodule

/* File: sim/hcl_loader_chk.sv */
// descriptor field assertions against bytes rebuilt from the link
// assumes 24 header bits per frame
`timescale 1ns/1ps
module hcl_loader_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        spi_sck,
    input wire        spi_cs_n,
    input wire        spi_miso,
    input wire        usb_high_speed,
    input wire        self_powered,
    input wire [15:0] vendor_id,
    input wire [15:0] product_id,
    input wire [15:0] device_release_id,
    input wire [3:0]  active_port_oc_filter_ms,
    input wire [3:0]  idle_port_oc_filter_ms,
    input wire [7:0]  upstream_draw_2ma,
    input wire [7:0]  controller_current_ma,
    input wire [7:0]  port_power_good_delay,
    input wire        oc_detect_disable,
    input wire [15:0] hub_characteristics,
    input wire        vendor_class_mode,
    input wire        config_ready
);
    reg  [7:0] img [0:18];
    reg  [7:0] nbit_q;
    reg  [7:0] sh_q;
    reg        sck_q;
    integer    i;
    wire [7:0] nxt  = {sh_q[6:0], spi_miso};
    wire [7:0] pos  = nbit_q - 8'h18;
    wire       idle = config_ready && spi_cs_n;
    // rebuilt from the wire to catch swapped bytes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nbit_q <= 8'h00;
            sh_q   <= 8'h00;
            sck_q  <= 1'b0;
            for (i = 0; i < 19; i = i + 1) begin
                img[i] <= 8'h00;
            end
        end else begin
            sck_q <= spi_sck;
            if (spi_cs_n) begin
                nbit_q <= 8'h00;
            end else if (spi_sck && !sck_q) begin
                nbit_q <= nbit_q + 8'h01;
                sh_q   <= nxt;
                if (nbit_q >= 8'h18 && pos[2:0] == 3'h7 && pos[7:3] < 5'h13) begin
                    img[pos[7:3]] <= nxt;
                end
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // three idle cycles after a good frame
    sequence s_settled;
        idle [*2] ##1 (idle && img[0] == 8'hD4);
    endsequence
    property p_cur(s, h, b);
        s_settled ##0 ($past(self_powered) == s && $past(usb_high_speed) == h) |-> controller_current_ma == b;
    endproperty
    property p_draw(h, b);
        s_settled ##0 ($past(usb_high_speed) == h) |-> upstream_draw_2ma == b;
    endproperty
    AST_VID: assert property (s_settled |-> vendor_id == {img[2], img[1]})
        else $error("vendor id wrong");
    AST_PID: assert property (s_settled |-> product_id == {img[4], img[3]})
        else $error("product id wrong");
    AST_DEVREL: assert property (s_settled |-> device_release_id == {img[6], 8'h00})
        else $error("release id wrong");
    AST_TIMERS: assert property (s_settled |-> {active_port_oc_filter_ms, idle_port_oc_filter_ms} == img[7])
        else $error("filter times wrong");
    AST_DRAW_FS: assert property (p_draw(1'b0, img[8]))
        else $error("full speed draw wrong");
    AST_DRAW_HS: assert property (p_draw(1'b1, img[9]))
        else $error("high speed draw wrong");
    AST_CUR_FS_BUS: assert property (p_cur(1'b0, 1'b0, img[12]))
        else $error("current wrong");
    AST_CUR_HS_BUS: assert property (p_cur(1'b0, 1'b1, img[13]))
        else $error("current wrong");
    AST_CUR_FS_SELF: assert property (p_cur(1'b1, 1'b0, img[14]))
        else $error("current wrong");
    AST_CUR_HS_SELF: assert property (p_cur(1'b1, 1'b1, img[15]))
        else $error("current wrong");
    AST_PGOOD: assert property (s_settled |-> port_power_good_delay == img[16])
        else $error("power good delay wrong");
    AST_OC_DIS: assert property (s_settled |-> {oc_detect_disable, hub_characteristics[4]}=={2{img[18][1]}})
        else $error("oc disable wrong");
    AST_BLANK: assert property (idle [*3] |-> vendor_class_mode == (img[0] == 8'hFF))
        else $error("vendor class mode wrong");
    AST_READY: assert property ($rose(spi_cs_n) |=> config_ready)
        else $error("ready late after frame");
endmodule

bind hcl_loader hcl_loader_chk i_hcl_loader_chk (.*);

/* File: sim/hcl_loader_bench.sv */
// self-checking bench for the hub configuration loader
// assumes an image read per load
`timescale 1ns/1ps
module hcl_loader_bench;
    reg         pclk    = 1'b0;
    reg         presetn = 1'b0;
    reg         psel    = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite  = 1'b0;
    reg  [11:0] paddr   = 12'h000;
    reg  [31:0] pwdata  = 32'h00000000;
    reg         hs      = 1'b0;
    reg         sp      = 1'b0;
    reg         slow    = 1'b0;
    reg  [31:0] q;
    reg         e;
    wire [31:0] prdata;
    wire [15:0] vid, pid, drel, hubc;
    wire [7:0]  draw, cur, pgood;
    wire [3:0]  act, idl;
    wire        pready, pslverr, sck, cs_n, mosi, miso, ocd, vcm, crdy;
    integer     bad_count = 0;
    integer     checks    = 0;
    integer     cyc       = 0;
    integer     k;
    hcl_loader #(.SPI_DIV(4)) i_hcl_loader (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
        .usb_high_speed(hs), .self_powered(sp), .vendor_id(vid), .product_id(pid),
        .device_release_id(drel), .active_port_oc_filter_ms(act), .idle_port_oc_filter_ms(idl),
        .upstream_draw_2ma(draw), .controller_current_ma(cur), .port_power_good_delay(pgood),
        .oc_detect_disable(ocd), .hub_characteristics(hubc), .vendor_class_mode(vcm), .config_ready(crdy)
    );
    hcl_eeprom_model i_hcl_eeprom_model (.sck(sck), .cs_n(cs_n), .mosi(mosi), .slow(slow), .miso(miso));
    initial begin
        forever #4 pclk = ~pclk;
    end
    // hang guard
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            report_and_stop;
        end
    end
    function [7:0] bv(input [7:0] n);
        bv = 8'h30 + 8'h0B * n;
    endfunction
    task check(input [31:0] seen, input [31:0] want);
        begin
            checks = checks + 1;
            if (seen !== want) begin
                bad_count = bad_count + 1;
                $display("wrong value at %0t: saw %h want %h", $time, seen, want);
            end
        end
    endtask
    // one apb transfer held until pready
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel    <= 1'b1;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            q = prdata;
            e = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wait_load;
        begin
            while (cs_n !== 1'b0) @(posedge pclk);
            while (cs_n !== 1'b1) @(posedge pclk);
            repeat (3) @(posedge pclk);
        end
    endtask
    // distinct byte per address, except bytes 10 and 11 both zero and bytes 0 and 18 fixed
    task fill(input [7:0] sig);
        integer n;
        begin
            for (n = 0; n < 64; n = n + 1) begin
                i_hcl_eeprom_model.mem[n] = bv(n[7:0]);
            end
            i_hcl_eeprom_model.mem[0]  = sig;
            i_hcl_eeprom_model.mem[10] = 8'h00;
            i_hcl_eeprom_model.mem[11] = 8'h00;
            i_hcl_eeprom_model.mem[18] = 8'h02;
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons %0d, mismatches %0d", checks, bad_count);
            if (bad_count == 0 && checks > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    initial begin
        fill(8'hD4);
        repeat (16) @(posedge pclk);
        check(draw, 8'h28);
        check(cur, 8'h50);
        check({act, idl}, 8'h88);
        check(pgood, 8'h32);
        presetn <= 1'b1;
        wait_load;
        check(crdy, 1'b1);
        check(i_hcl_eeprom_model.cmd_q, 24'h030000);
        check(vcm, 1'b0);
        check(vid, {bv(2), bv(1)});
        check(pid, {bv(4), bv(3)});
        check(drel, {bv(6), 8'h00});
        check({act, idl}, bv(7));
        check(pgood, bv(16));
        check({ocd, hubc[4]}, 2'b11);
        // all speed/power pairs
        for (k = 0; k < 4; k = k + 1) begin
            sp <= k[1];
            hs <= k[0];
            repeat (2) @(posedge pclk);
            check(draw, k[0] ? bv(9) : bv(8));
            check(cur, bv(8'd12 + k[7:0]));
        end
        apb(1'b0, 12'h008, 32'h0);
        check(q, {bv(4), bv(3), bv(2), bv(1)});
        apb(1'b0, 12'h004, 32'h0);
        check(q[2:1], 2'b11);
        apb(1'b0, 12'h0FC, 32'h0);
        check({e, q}, 33'h100000000);
        // slow reload, new vendor byte
        slow <= 1'b1;
        i_hcl_eeprom_model.mem[1] = 8'hA5;
        apb(1'b1, 12'h000, 32'h1);
        wait_load;
        check(vid, {bv(2), 8'hA5});
        fill(8'hD2);
        i_hcl_eeprom_model.mem[1] = 8'h5A;
        apb(1'b1, 12'h000, 32'h1);
        wait_load;
        check(vid, {bv(2), 8'hA5});
        check(vcm, 1'b0);
        apb(1'b0, 12'h004, 32'h0);
        check(q[4], 1'b1);
        fill(8'hFF);
        apb(1'b1, 12'h000, 32'h1);
        wait_load;
        check(vcm, 1'b1);
        report_and_stop;
    end
endmodule
